/* synth_prog_pkg.sv */
// constants for the serially loaded divider programming registers
// assumes a 22-bit word: 20 data bits above a 2-bit address field
package synth_prog_pkg;
    localparam int WORD_W = 22;
    localparam int DATA_W = 20;
    localparam int ADDR_W = 2;
    // register addresses carried in the low two bits of the word
    localparam logic [1:0] ADDR_AUX_REF = 2'h0;
    localparam logic [1:0] ADDR_AUX_FB = 2'h1;
    localparam logic [1:0] ADDR_MAIN_REF = 2'h2;
    localparam logic [1:0] ADDR_MAIN_FB = 2'h3;
    // field positions inside the 20-bit data field
    localparam int REF_COUNT_W = 15;
    localparam int MODE_LSB = 15;
    localparam int MODE_W = 5;
    localparam int SWALLOW_LSB = 0;
    localparam int SWALLOW_W = 5;
    localparam int PROG_LSB = 5;
    localparam int PROG_W = 13;
    localparam int PRESCALER_BIT = 18;
    localparam int POWERDOWN_BIT = 19;
    // reset value of every held register
    localparam logic [19:0] REG_RESET = 20'h00000;
    localparam int SYNC_STAGES = 3;
endpackage

/* synth_prog_regs.sv */
// three-wire serial programming of the dual synthesizer divider registers
// assumes serial_clk is the host's link clock, idle between frames
`timescale 1ns/1ps
module synth_prog_regs
    import synth_prog_pkg::*;
(
    // system
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial link
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    // aux loop settings
    output logic [14:0] aux_reference_count,
    output logic [4:0] aux_mode_bits,
    output logic [4:0] aux_swallow_count,
    output logic [12:0] aux_programmable_count,
    output logic aux_prescaler_sel,
    output logic aux_powerdown_bit,
    // main loop settings
    output logic [14:0] main_reference_count,
    output logic [4:0] main_mode_bits,
    output logic [4:0] main_swallow_count,
    output logic [12:0] main_programmable_count,
    output logic main_prescaler_sel,
    output logic main_powerdown_bit,
    // load event
    output logic load_pulse
);

    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b01,
        LOAD_HIGH = 2'b10
    } load_state_type;

    // ---------------------------------------------------------------
    // link domain shift register
    // ---------------------------------------------------------------
    logic [WORD_W-1:0] shift_ff;

    always_ff @(posedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_ff <= '0;
        end else if (!load_strobe) begin
            shift_ff <= {shift_ff[WORD_W-2:0], serial_data};
        end
    end

    // ---------------------------------------------------------------
    // strobe synchroniser and word capture
    // ---------------------------------------------------------------
    // the shift register is quiet while the strobe is high, so the
    // word is stable when the synchronised rising edge is seen
    logic [SYNC_STAGES-1:0] strobe_sync_ff;
    load_state_type load_state_ff;
    logic strobe_rise;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_sync_ff <= '0;
        end else begin
            strobe_sync_ff <= {strobe_sync_ff[SYNC_STAGES-2:0], load_strobe};
        end
    end

    // a level change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_state_ff <= LOAD_IDLE;
        end else begin
            case (load_state_ff)
                LOAD_IDLE: begin
                    if (strobe_sync_ff[1] && strobe_sync_ff[2]) begin
                        load_state_ff <= LOAD_HIGH;
                    end
                end
                LOAD_HIGH: begin
                    if (!strobe_sync_ff[1] && !strobe_sync_ff[2]) begin
                        load_state_ff <= LOAD_IDLE;
                    end
                end
                default: load_state_ff <= LOAD_IDLE;
            endcase
        end
    end

    assign strobe_rise = (load_state_ff == LOAD_IDLE) && strobe_sync_ff[1] && strobe_sync_ff[2];

    // ---------------------------------------------------------------
    // register bank
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] aux_ref_ff;
    logic [DATA_W-1:0] aux_fb_ff;
    logic [DATA_W-1:0] main_ref_ff;
    logic [DATA_W-1:0] main_fb_ff;
    logic load_pulse_ff;
    logic [DATA_W-1:0] word_data;
    logic [ADDR_W-1:0] word_addr;

    assign word_data = shift_ff[WORD_W-1:ADDR_W];
    assign word_addr = shift_ff[ADDR_W-1:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_ref_ff <= REG_RESET;
            aux_fb_ff <= REG_RESET;
            main_ref_ff <= REG_RESET;
            main_fb_ff <= REG_RESET;
        end else if (strobe_rise) begin
            case (word_addr)
                ADDR_AUX_REF: aux_ref_ff <= word_data;
                ADDR_AUX_FB: aux_fb_ff <= word_data;
                ADDR_MAIN_REF: main_ref_ff <= word_data;
                ADDR_MAIN_FB: main_fb_ff <= word_data;
                default: aux_ref_ff <= aux_ref_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_pulse_ff <= 1'b0;
        end else begin
            load_pulse_ff <= strobe_rise;
        end
    end

    // ---------------------------------------------------------------
    // field split
    // ---------------------------------------------------------------
    // reference count low bits
    assign aux_reference_count = aux_ref_ff[REF_COUNT_W-1:0];
    assign main_reference_count = main_ref_ff[REF_COUNT_W-1:0];
    assign aux_mode_bits = aux_ref_ff[MODE_LSB +: MODE_W];
    assign main_mode_bits = main_ref_ff[MODE_LSB +: MODE_W];
    assign aux_swallow_count = aux_fb_ff[SWALLOW_LSB +: SWALLOW_W];
    assign aux_programmable_count = aux_fb_ff[PROG_LSB +: PROG_W];
    assign main_swallow_count = main_fb_ff[SWALLOW_LSB +: SWALLOW_W];
    assign main_programmable_count = main_fb_ff[PROG_LSB +: PROG_W];
    assign aux_prescaler_sel = aux_fb_ff[PRESCALER_BIT];
    assign aux_powerdown_bit = aux_fb_ff[POWERDOWN_BIT];
    assign main_prescaler_sel = main_fb_ff[PRESCALER_BIT];
    assign main_powerdown_bit = main_fb_ff[POWERDOWN_BIT];
    assign load_pulse = load_pulse_ff;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    AST_LOAD_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise |=> load_pulse)
        else $error("load pulse missing after strobe rise");

    AST_AUX_REF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise && word_addr == ADDR_AUX_REF |=> aux_ref_ff == $past(word_data))
        else $error("aux reference not loaded");

    AST_MAIN_REF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise && word_addr == ADDR_MAIN_REF |=> main_reference_count
        == $past(word_data[14:0]))
        else $error("main reference not loaded");

    AST_MAIN_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise && word_addr == ADDR_MAIN_REF |=> main_mode_bits
        == $past(word_data[19:15]))
        else $error("main mode bits wrong");

    AST_AUX_FB: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise && word_addr == ADDR_AUX_FB |=> aux_programmable_count
        == $past(word_data[17:5]) && aux_swallow_count == $past(word_data[4:0]))
        else $error("aux feedback split wrong");

    AST_MAIN_FB: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise && word_addr == ADDR_MAIN_FB |=> main_fb_ff == $past(word_data))
        else $error("main feedback not loaded");

    AST_PWDN_BIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise && word_addr == ADDR_MAIN_FB |=> main_powerdown_bit
        == $past(shift_ff[21]) && main_prescaler_sel == $past(shift_ff[20]))
        else $error("powerdown or prescaler bit wrong");

    AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !strobe_rise || word_addr != ADDR_AUX_FB |=> $stable(aux_fb_ff))
        else $error("unaddressed register changed");

    AST_HOLD_MAIN_REF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !strobe_rise || word_addr != ADDR_MAIN_REF |=> $stable(main_ref_ff))
        else $error("unaddressed main reference changed");

    AST_SHIFT_FROZEN: assert property (@(posedge serial_clk) disable iff (!rst_n)
        $past(load_strobe) |-> $stable(shift_ff))
        else $error("shift register moved under high strobe");

    AST_ONE_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise |=> !strobe_rise)
        else $error("two loads for one strobe");

    COV_AUX_REF: cover property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise && word_addr == ADDR_AUX_REF);
    COV_MAIN_FB: cover property (@(posedge ref_clk) disable iff (!rst_n)
        strobe_rise && word_addr == ADDR_MAIN_FB);
    COV_BACK: cover property (@(posedge ref_clk) disable iff (!rst_n)
        load_pulse ##[1:200] load_pulse);

endmodule

/* host_link_model.sv */
// host model driving the three-wire divider programming link
// assumes callers space frames; link clock stands low between frames
`timescale 1ns/1ps
module host_link_model (
    // serial link
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    // ----------------------------------------
    // frame transfer
    // ----------------------------------------
    // msb first
    task automatic send(input logic [31:0] w, input int n, input bit stray);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            #24 serial_clk = 1'b1;
            #24 serial_clk = 1'b0;
        end
        serial_data = ~serial_data;
        #24 load_strobe = 1'b1;
        for (int i = 0; i < 3 && stray; i++) begin
            serial_data = ~serial_data;
            #12 serial_clk = 1'b1;
            #12 serial_clk = 1'b0;
        end
        #96 load_strobe = 1'b0;
        serial_data = ~serial_data;
        #96;
    endtask
endmodule

/* dual_pll_divider_program_regs_tb.sv */
// self-checking bench for the divider programming registers
// assumes host_link_model plays the host on the serial link
`timescale 1ns/1ps
module dual_pll_divider_program_regs_tb;
    import synth_prog_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic serial_clk, serial_data, load_strobe, load_pulse;
    logic aux_prescaler_sel, aux_powerdown_bit, main_prescaler_sel, main_powerdown_bit;
    logic [14:0] aux_reference_count, main_reference_count;
    logic [4:0] aux_mode_bits, aux_swallow_count, main_mode_bits, main_swallow_count;
    logic [12:0] aux_programmable_count, main_programmable_count;
    logic [19:0] exp_regs [4] = '{default: 20'h00000};
    logic [79:0] exp_q [$];
    logic [79:0] seen;
    int seed = 22876;
    int mismatches = 0;
    int n_compared = 0;
    host_link_model host (.serial_clk, .serial_data, .load_strobe);
    synth_prog_regs dut (.ref_clk, .rst_n, .serial_clk, .serial_data, .load_strobe,
        .aux_reference_count, .aux_mode_bits, .aux_swallow_count, .aux_programmable_count,
        .aux_prescaler_sel, .aux_powerdown_bit, .main_reference_count, .main_mode_bits,
        .main_swallow_count, .main_programmable_count, .main_prescaler_sel,
        .main_powerdown_bit, .load_pulse);
    assign seen = {main_powerdown_bit, main_prescaler_sel, main_programmable_count,
        main_swallow_count, main_mode_bits, main_reference_count, aux_powerdown_bit,
        aux_prescaler_sel, aux_programmable_count, aux_swallow_count, aux_mode_bits,
        aux_reference_count};
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [19:0] make(input logic [1:0] a);
        logic [19:0] r;
        r = 20'($random(seed));
        if (!a[0]) return {r[19:15], 15'(2 + {r} % 32766)};
        return {r[19:18], 13'(3 + {r} % 8189), 5'(r[1:0])};
    endfunction
    task automatic load(input logic [19:0] d, input logic [1:0] a, input int extra,
        input bit stray);
        exp_regs[a] = d;
        exp_q.push_back({exp_regs[3], exp_regs[2], exp_regs[1], exp_regs[0]});
        host.send({10'($random(seed)), d, a}, 22 + extra, stray);
    endtask
    // ----------------------------------------
    // output monitor
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (load_pulse === 1'b1 && exp_q.size() == 0) begin
            check(seen, 80'hX);
        end else if (load_pulse === 1'b1) begin
            check(seen, exp_q.pop_front());
        end
    end
    initial begin
        #500us;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check(seen, 80'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            load(make(2'(i)), 2'(i), 0, 1'b0);
        end
        $display("random test done");
        load({5'h1F, 15'h0002}, ADDR_MAIN_REF, 0, 1'b0);
        load({5'h00, 15'h7FFF}, ADDR_AUX_REF, 0, 1'b0);
        load({2'h3, 13'h1FFF, 5'h1F}, ADDR_MAIN_FB, 0, 1'b0);
        load({2'h0, 13'h0003, 5'h00}, ADDR_AUX_FB, 0, 1'b0);
        $display("boundary test done");
        load(make(ADDR_MAIN_REF), ADDR_MAIN_REF, 7, 1'b1);
        load(make(ADDR_AUX_FB), ADDR_AUX_FB, 3, 1'b1);
        $display("overlength and stray clock test done");
        repeat (10) @(posedge ref_clk);
        check(80'(exp_q.size()), 80'h0);
        end_sim();
    end
endmodule
